// *** rtl/servo_io.sv ***
// Discrete I/O, shutoff and encoder pulse logic of the servo drive
//
// Overview of operation
// R1 - A forward or reverse travel block input stops motion that way.
// R2 - The travel stop is done by this logic; external safety is extra.
// R3 - The alarm output is off while an error is detected, else on.
// R4 - The brake release output is on to release and off to hold.
// R5 - Configuration can turn the brake output into general output 1.
// R6 - General outputs 2 and 3 carry the function chosen for them.
// R7 - Eight status functions can each be routed to an output pin.
// R8 - Phase A and B outputs are differential, B a quarter period apart.
// R9 - A differential origin pulse marks the encoder origin.
// R10 - Motor current is cut while either shutoff input is off.
// R11 - The monitor is on only with both shutoffs active and current cut.
// R12 - General input 0 and option inputs 3 to 6 go to the option module.
// R13 - Input functions are mapped to physical pins by configuration.
// R14 - General outputs 1 to 3 are mapped to pins by configuration.
// R15 - A pin shared by several functions drives all of them at once.
// R16 - Every pin input is synchronised before any function uses it.
`default_nettype none
module servo_io
  import servo_io_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,

  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,

  // Connector input pins and shutoff inputs (high = energised)
  input  wire logic [6:0]  pin_in_i,
  input  wire logic        hard_shutoff_in_1_i,
  input  wire logic        hard_shutoff_in_2_i,

  // Status from the motion core
  input  wire logic        error_detected_i,
  input  wire logic        brake_release_req_i,
  input  wire logic        positioning_done_i,
  input  wire logic        speed_match_i,
  input  wire logic        motion_detected_i,
  input  wire logic        drive_ready_i,
  input  wire logic        force_limited_i,
  input  wire logic        speed_limited_i,
  input  wire logic        warning_i,
  input  wire logic        near_position_i,

  // Encoder position steps from the motion core
  input  wire logic        enc_step_i,
  input  wire logic        enc_dir_i,
  input  wire logic        enc_origin_i,

  // Controls to the motion core and option module
  output logic             forward_stop_o,
  output logic             reverse_stop_o,
  output logic             motor_current_off_o,
  output logic [4:0]       option_input_o,

  // Connector output pins (high = on)
  output logic             alarm_out_o,
  output logic [2:0]       out_pin_o,
  output logic             phase_a_out_o,
  output logic             phase_a_out_n_o,
  output logic             phase_b_out_o,
  output logic             phase_b_out_n_o,
  output logic             origin_pulse_out_o,
  output logic             origin_pulse_out_n_o,
  output logic             shutoff_monitor_out_o
);

  typedef struct packed {
    // Registers
    logic [1:0]            ctrl;
    logic [27:0]           in_map;
    logic [11:0]           out_func;
    logic [5:0]            out_pin;
    logic [NUM_EVENTS-1:0] irq_stat;
    logic [NUM_EVENTS-1:0] irq_mask;
    logic                  irq;

    // Pin side
    logic [6:0]            func;
    logic                  shutoff;
    logic                  monitor;
    logic                  alarm;
    logic [4:0]            opt;
    logic [2:0]            pins;

    // Encoder
    logic [1:0]            enc_cnt;
    logic                  pa;
    logic                  pa_n;
    logic                  pb;
    logic                  pb_n;
    logic                  pc;
    logic                  pc_n;

    // Bus answer
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } io_state_s;

  io_state_s st_r;
  io_state_s st_nxt;

  // Synced levels
  logic [8:0] sync_w;
  logic [6:0] pins_w;
  logic       shut1_w;
  logic       shut2_w;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for all connector inputs
  input_sync #(
    .WIDTH (9)
  ) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .async_i  ({hard_shutoff_in_2_i, hard_shutoff_in_1_i, pin_in_i}),
    .sync_o   (sync_w)
  ); // R16

  assign pins_w  = sync_w[6:0];
  assign shut1_w = sync_w[7];
  assign shut2_w = sync_w[8];

  ////////////////////////////////////////////////////////////////////////////
  // Input selector: pin direct, constant on or off, or pin inverted
  function automatic logic map_in(input logic [3:0] sel,
                                  input logic [6:0] pins);
    logic [3:0] inv;

    inv = sel - SEL_FIRST_INV;
    if (sel <= SEL_LAST_DIRECT) begin
      map_in = pins[sel[2:0]];
    end else if (sel == SEL_ALWAYS_ON) begin
      map_in = 1'b1;
    end else if (sel == SEL_ALWAYS_OFF) begin
      map_in = 1'b0;
    end else begin
      map_in = ~pins[inv[2:0]];
    end
  endfunction

  // Status function selected for one general output
  function automatic logic out_sel(input logic [3:0] code,
                                   input logic [8:0] stat);
    case (out_func_e'(code))
      OF_NONE:      out_sel = 1'b0;
      OF_POS_DONE:  out_sel = stat[0];
      OF_SPD_MATCH: out_sel = stat[1];
      OF_MOTION:    out_sel = stat[2];
      OF_READY:     out_sel = stat[3];
      OF_FORCE_LIM: out_sel = stat[4];
      OF_SPEED_LIM: out_sel = stat[5];
      OF_WARNING:   out_sel = stat[6];
      OF_NEAR:      out_sel = stat[7];
      OF_SOFTWARE:  out_sel = stat[8];
      default:      out_sel = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [8:0]            stat;
    logic [2:0]            gout;
    logic [NUM_EVENTS-1:0] ev;
    logic [NUM_EVENTS-1:0] clr;
    logic                  setup;
    logic                  wr;
    logic [1:0]            psel_pin;

    stat     = '0;
    gout     = '0;
    ev       = '0;
    clr      = '0;
    psel_pin = '0;
    st_nxt   = st_r;

    setup    = psel_i && !penable_i;
    wr       = psel_i && penable_i && pwrite_i && st_r.pready;

    // Map each input function onto its selected pin
    for (int f = 0; f < NUM_IN_FUNCS; f++) begin
      st_nxt.func[f] = map_in(st_r.in_map[4*f +: 4], pins_w); // R13 R15
    end

    // Option module inputs follow the mapped functions
    st_nxt.opt = st_r.func[FN_GI0 +: 5]; // R12

    // Current cut while either shutoff input is off
    st_nxt.shutoff = !(shut1_w && shut2_w); // R10
    // Monitor on with both shutoffs active and the cut in force
    st_nxt.monitor = !shut1_w && !shut2_w && st_r.shutoff; // R11

    // Alarm output switches off on a detected error
    st_nxt.alarm = !error_detected_i; // R3

    // Route status functions to the general outputs
    stat = {st_r.ctrl[CTRL_SW_OUT_BIT], near_position_i, warning_i,
            speed_limited_i, force_limited_i, drive_ready_i,
            motion_detected_i, speed_match_i, positioning_done_i};

    for (int o = 0; o < NUM_OUTS; o++) begin
      gout[o] = out_sel(st_r.out_func[4*o +: 4], stat); // R6 R7
    end

    // Place the general outputs onto their selected pins
    st_nxt.pins = '0;
    for (int o = 0; o < NUM_OUTS; o++) begin
      psel_pin = st_r.out_pin[2*o +: 2];
      if (psel_pin != 2'h0) begin
        if (gout[o]) begin
          st_nxt.pins[psel_pin - 2'h1] = 1'b1; // R14
        end
      end
    end

    // Pin 0 carries the brake unless turned into general output 1
    if (!st_r.ctrl[CTRL_BRAKE_GPO_BIT]) begin
      st_nxt.pins[0] = brake_release_req_i; // R4 R5
    end

    // Quadrature counter: A and B a quarter period apart
    if (enc_step_i) begin
      if (enc_dir_i) begin
        st_nxt.enc_cnt = st_r.enc_cnt + 2'h1;
      end else begin
        st_nxt.enc_cnt = st_r.enc_cnt - 2'h1;
      end
    end

    st_nxt.pa   = st_nxt.enc_cnt[1]; // R8
    st_nxt.pa_n = ~st_nxt.enc_cnt[1];
    st_nxt.pb   = st_nxt.enc_cnt[1] ^ st_nxt.enc_cnt[0]; // R8
    st_nxt.pb_n = ~(st_nxt.enc_cnt[1] ^ st_nxt.enc_cnt[0]);

    st_nxt.pc   = enc_origin_i; // R9
    st_nxt.pc_n = ~enc_origin_i;

    // Events: travel block entry, current cut entry, alarm entry
    ev[EV_FWD]   = st_nxt.func[FN_FWD] && !st_r.func[FN_FWD];
    ev[EV_REV]   = st_nxt.func[FN_REV] && !st_r.func[FN_REV];
    ev[EV_SHUT]  = st_nxt.shutoff && !st_r.shutoff;
    ev[EV_ALARM] = !st_nxt.alarm && st_r.alarm;

    // APB register writes in the access phase
    if (wr) begin
      case (paddr_i)
        ADDR_CTRL:     st_nxt.ctrl     = pwdata_i[1:0];
        ADDR_IN_MAP:   st_nxt.in_map   = pwdata_i[27:0];
        ADDR_OUT_FUNC: st_nxt.out_func = pwdata_i[11:0];
        ADDR_OUT_PIN:  st_nxt.out_pin  = pwdata_i[5:0];
        ADDR_IRQ_STAT: clr             = pwdata_i[NUM_EVENTS-1:0];
        ADDR_IRQ_MASK: st_nxt.irq_mask = pwdata_i[NUM_EVENTS-1:0];
        default:       clr             = '0;
      endcase
    end

    // Sticky status: a new event wins over its clear
    st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
    st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);

    // Read data and answer prepared in the setup cycle
    st_nxt.pready  = setup;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata  = '0;

    if (setup) begin
      case (paddr_i)
        ADDR_CTRL:     st_nxt.prdata[1:0]  = st_r.ctrl;
        ADDR_IN_MAP:   st_nxt.prdata[27:0] = st_r.in_map;
        ADDR_OUT_FUNC: st_nxt.prdata[11:0] = st_r.out_func;
        ADDR_OUT_PIN:  st_nxt.prdata[5:0]  = st_r.out_pin;
        ADDR_IN_STATE: begin
          st_nxt.prdata[6:0] = st_r.func;
          st_nxt.prdata[IN_STATE_PIN_LSB +: 7] = pins_w;
          st_nxt.prdata[IN_STATE_SHUT_LSB +: 2] = {shut2_w, shut1_w};
          st_nxt.prdata[IN_STATE_SHUT_LSB + 2] = st_r.shutoff;
        end
        ADDR_IRQ_STAT: st_nxt.prdata[3:0] = st_r.irq_stat;
        ADDR_IRQ_MASK: st_nxt.prdata[3:0] = st_r.irq_mask;
        default:       st_nxt.pslverr     = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset holds the drive in the safe state
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r          <= '0;
      st_r.ctrl     <= CTRL_RST;
      st_r.in_map   <= IN_MAP_RST;
      st_r.out_func <= OUT_FUNC_RST;
      st_r.out_pin  <= OUT_PIN_RST;
      st_r.irq_mask <= IRQ_MASK_RST;
      // Safe state
      st_r.shutoff  <= 1'b1;
      st_r.pa_n     <= 1'b1;
      st_r.pb_n     <= 1'b1;
      st_r.pc_n     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign forward_stop_o        = st_r.func[FN_FWD]; // R1 R2
  assign reverse_stop_o        = st_r.func[FN_REV]; // R1 R2
  assign motor_current_off_o   = st_r.shutoff;      // R10
  assign option_input_o        = st_r.opt;

  // Connector pins
  assign alarm_out_o           = st_r.alarm;
  assign out_pin_o             = st_r.pins;
  assign phase_a_out_o         = st_r.pa;
  assign phase_a_out_n_o       = st_r.pa_n;
  assign phase_b_out_o         = st_r.pb;
  assign phase_b_out_n_o       = st_r.pb_n;
  assign origin_pulse_out_o    = st_r.pc;
  assign origin_pulse_out_n_o  = st_r.pc_n;
  assign shutoff_monitor_out_o = st_r.monitor;

  // Bus side
  assign prdata_o              = st_r.prdata;
  assign pready_o              = st_r.pready;
  assign pslverr_o             = st_r.pslverr;
  assign irq_o                 = st_r.irq;

endmodule
`default_nettype wire

// *** rtl/servo_io_pkg.sv ***
// Shared constants and types for the servo drive discrete signal logic
`default_nettype none
package servo_io_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_IN_MAP    = 8'h04;
  localparam logic [7:0] ADDR_OUT_FUNC  = 8'h08;
  localparam logic [7:0] ADDR_OUT_PIN   = 8'h0C;
  localparam logic [7:0] ADDR_IN_STATE  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and sizes
  localparam int CTRL_BRAKE_GPO_BIT = 0;  // Pin 0 acts as general output 1
  localparam int CTRL_SW_OUT_BIT    = 1;  // Software-driven output level
  localparam int NUM_IN_PINS        = 7;  // Physical input circuits
  localparam int NUM_IN_FUNCS       = 7;  // Mapped input functions
  localparam int NUM_OUTS           = 3;  // General outputs and pins
  localparam int NUM_EVENTS         = 4;  // Interrupt sources
  localparam int IN_STATE_PIN_LSB   = 8;  // Raw pins in input state reg
  localparam int IN_STATE_SHUT_LSB  = 16; // Shutoff inputs in state reg

  // Input function index within the input map
  localparam int FN_FWD = 0;
  localparam int FN_REV = 1;
  localparam int FN_GI0 = 2;
  localparam int FN_OI3 = 3;

  // Interrupt event bit positions
  localparam int EV_FWD   = 0;
  localparam int EV_REV   = 1;
  localparam int EV_SHUT  = 2;
  localparam int EV_ALARM = 3;

  // Input selector codes: pins direct, constant, pins inverted
  localparam logic [3:0] SEL_LAST_DIRECT = 4'h6;
  localparam logic [3:0] SEL_ALWAYS_ON   = 4'h7;
  localparam logic [3:0] SEL_ALWAYS_OFF  = 4'h8;
  localparam logic [3:0] SEL_FIRST_INV   = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam logic [27:0] IN_MAP_RST   = 28'h654_3021;
  localparam logic [11:0] OUT_FUNC_RST = 12'h410;
  localparam logic [5:0]  OUT_PIN_RST  = 6'h39;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  // Status function codes for a general output
  typedef enum logic [3:0] {
    OF_NONE      = 4'b0000,
    OF_POS_DONE  = 4'b0001,
    OF_SPD_MATCH = 4'b0010,
    OF_MOTION    = 4'b0011,
    OF_READY     = 4'b0100,
    OF_FORCE_LIM = 4'b0101,
    OF_SPEED_LIM = 4'b0110,
    OF_WARNING   = 4'b0111,
    OF_NEAR      = 4'b1000,
    OF_SOFTWARE  = 4'b1001
  } out_func_e;

endpackage
`default_nettype wire

// *** rtl/input_sync.sv ***
// Three-stage synchroniser with agreement filter for pin inputs
`default_nettype none
module input_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  // Raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_state_s;

  sync_state_s st_r;
  sync_state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Shift chain; output takes a bit only once stages two and three agree
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.q;

endmodule
`default_nettype wire

// *** test/servo_io_assertions.sv ***
// Port-level assertions for the servo drive discrete signal logic
`default_nettype none
module servo_io_assertions (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Causes
  input wire logic error_detected_i,
  input wire logic hard_shutoff_in_1_i,
  input wire logic hard_shutoff_in_2_i,
  input wire logic enc_step_i,
  // Effects
  input wire logic alarm_out_o,
  input wire logic phase_a_out_o,
  input wire logic phase_a_out_n_o,
  input wire logic phase_b_out_o,
  input wire logic phase_b_out_n_o,
  input wire logic origin_pulse_out_o,
  input wire logic origin_pulse_out_n_o,
  input wire logic motor_current_off_o,
  input wire logic shutoff_monitor_out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  ////////////////////////////////////////////////////////////////////////////
  // Shutoff levels held long enough to pass the synchroniser
  sequence s_any_off;
    !(hard_shutoff_in_1_i && hard_shutoff_in_2_i) [*7];
  endsequence
  sequence s_both_off;
    (!hard_shutoff_in_1_i && !hard_shutoff_in_2_i) [*8];
  endsequence
  sequence s_one_on;
    (hard_shutoff_in_1_i || hard_shutoff_in_2_i) [*7];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Output relations
  property p_alarm;
    $past(resetn_i) |-> alarm_out_o == !$past(error_detected_i);
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm level does not follow error");
  property p_diff_ab;
    phase_a_out_n_o == !phase_a_out_o && phase_b_out_n_o == !phase_b_out_o;
  endproperty
  a_diff_ab: assert property (p_diff_ab)
    else $error("phase pair not complementary");
  property p_diff_c; origin_pulse_out_n_o == !origin_pulse_out_o; endproperty
  a_diff_c: assert property (p_diff_c)
    else $error("origin pair not complementary");
  property p_step;
    enc_step_i |=> $changed(phase_a_out_o) != $changed(phase_b_out_o);
  endproperty
  a_step: assert property (p_step)
    else $error("step did not move exactly one phase");
  property p_cut; s_any_off |-> motor_current_off_o; endproperty
  a_cut: assert property (p_cut)
    else $error("current not cut with a shutoff input off");
  property p_mon_cause;
    shutoff_monitor_out_o |-> $past(motor_current_off_o);
  endproperty
  a_mon_cause: assert property (p_mon_cause)
    else $error("monitor on without current cut");
  property p_mon_on; s_both_off |-> shutoff_monitor_out_o; endproperty
  a_mon_on: assert property (p_mon_on)
    else $error("monitor off with both inputs off");
  property p_mon_off; s_one_on |-> !shutoff_monitor_out_o; endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("monitor on with a shutoff input on");
endmodule

bind servo_io servo_io_assertions u_chk (
  .clock_i, .resetn_i, .error_detected_i, .hard_shutoff_in_1_i,
  .hard_shutoff_in_2_i, .enc_step_i, .alarm_out_o, .phase_a_out_o,
  .phase_a_out_n_o, .phase_b_out_o, .phase_b_out_n_o, .origin_pulse_out_o,
  .origin_pulse_out_n_o, .motor_current_off_o, .shutoff_monitor_out_o
);
`default_nettype wire

// *** test/host_model.sv ***
// Far side: host contacts and safety relay driving the drive's inputs
`default_nettype none
module host_model (
  // Clock and requested levels
  input  wire logic       clock_i,
  input  wire logic [6:0] pin_req_i,
  input  wire logic [1:0] shut_req_i,
  // Lines into the drive
  output var  logic [6:0] pin_in_o,
  output var  logic       shut_1_o,
  output var  logic       shut_2_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Contacts open, both safety channels closed at power up
  initial begin
    pin_in_o = 7'h00;
    {shut_2_o, shut_1_o} = 2'h3;
  end

  // Contacts take the requested levels at a drive clock edge
  always @(posedge clock_i) begin
    pin_in_o <= pin_req_i;
    {shut_2_o, shut_1_o} <= shut_req_i;
  end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the servo drive discrete signal logic
`default_nettype none
module tb
  import servo_io_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i = 1'b0, resetn_i = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = '0, prdata_o, rdata;
  logic        pready_o, pslverr_o, irq_o, rerr;
  logic [6:0]  pin_in_i, pin_req = 7'h00;
  logic [1:0]  shut_req = 2'h3;
  logic [7:0]  st = 8'h00;
  logic        hard_shutoff_in_1_i, hard_shutoff_in_2_i;
  logic        error_detected_i = 1'b0, brake_release_req_i = 1'b0;
  logic        positioning_done_i, speed_match_i, motion_detected_i;
  logic        drive_ready_i, force_limited_i, speed_limited_i;
  logic        warning_i, near_position_i;
  logic        enc_step_i = 1'b0, enc_dir_i = 1'b0, enc_origin_i = 1'b0;
  logic        forward_stop_o, reverse_stop_o, motor_current_off_o;
  logic [4:0]  option_input_o;
  logic [2:0]  out_pin_o;
  logic        alarm_out_o, phase_a_out_o, phase_a_out_n_o, phase_b_out_o;
  logic        phase_b_out_n_o, origin_pulse_out_o, origin_pulse_out_n_o;
  logic        shutoff_monitor_out_o;
  int          error_cnt = 0, comparisons = 0;

  // Status functions in output function code order
  assign {near_position_i, warning_i, speed_limited_i, force_limited_i,
          drive_ready_i, motion_detected_i, speed_match_i,
          positioning_done_i} = st;

  servo_io u_dut (
    .clock_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o, .pin_in_i,
    .hard_shutoff_in_1_i, .hard_shutoff_in_2_i, .error_detected_i,
    .brake_release_req_i, .positioning_done_i, .speed_match_i,
    .motion_detected_i, .drive_ready_i, .force_limited_i,
    .speed_limited_i, .warning_i, .near_position_i, .enc_step_i,
    .enc_dir_i, .enc_origin_i, .forward_stop_o, .reverse_stop_o,
    .motor_current_off_o, .option_input_o, .alarm_out_o, .out_pin_o,
    .phase_a_out_o, .phase_a_out_n_o, .phase_b_out_o, .phase_b_out_n_o,
    .origin_pulse_out_o, .origin_pulse_out_n_o, .shutoff_monitor_out_o
  );
  host_model u_host (
    .clock_i, .pin_req_i(pin_req), .shut_req_i(shut_req),
    .pin_in_o(pin_in_i), .shut_1_o(hard_shutoff_in_1_i),
    .shut_2_o(hard_shutoff_in_2_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Drive clock, 100 ns period
  always #50 clock_i = ~clock_i;

  // Compare one value and count the outcome
  task automatic chk(input string w, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", w, e, s);
    end
  endtask

  // Wait whole cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // Register bus transfer: setup, access held until ready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask

  // One encoder step pulse
  task automatic step(input logic up);
    enc_dir_i <= up;
    enc_step_i <= 1'b1;
    @(posedge clock_i);
    enc_step_i <= 1'b0;
    @(posedge clock_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, then an unmapped word: reads zero, flags an error
  task automatic t_regs();
    logic [7:0]  a [6] = '{ADDR_CTRL, ADDR_IN_MAP, ADDR_OUT_FUNC,
                           ADDR_OUT_PIN, ADDR_IRQ_MASK, 8'h1C};
    logic [31:0] e [6] = '{32'h0000_0000, 32'h0654_3021, 32'h0000_0410,
                           32'h0000_0039, 32'h0000_0000, 32'h0000_0000};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, a[i], 32'h0000_0000);
      chk("reg", rdata, e[i]);
      chk("slverr", rerr, i == 5);
    end
  endtask

  // Travel block via pin map, shared pin, constant codes, interrupt
  task automatic t_travel();
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    pin_req[1] <= 1'b1;
    cyc(3);
    chk("fwd early", forward_stop_o, 1'b0);
    cyc(7);
    chk("stops", {forward_stop_o, reverse_stop_o}, 2'h2);
    chk("irq set", irq_o, 1'b1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0001);
    cyc(1);
    chk("irq clr", irq_o, 1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, ADDR_IN_MAP, 32'h0654_3011);
    cyc(6);
    chk("shared", {forward_stop_o, reverse_stop_o}, 2'h3);
    chk("irq mask", irq_o, 1'b0);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0000_0000);
    chk("stat", rdata, 32'h0000_0002);
    pin_req[1] <= 1'b0;
    cyc(8);
    chk("shared off", {forward_stop_o, reverse_stop_o}, 2'h0);
    apb(1'b1, ADDR_IN_MAP, 32'h0654_3087);
    cyc(4);
    chk("const", {forward_stop_o, reverse_stop_o}, 2'h2);
    apb(1'b1, ADDR_IN_MAP, 32'h0654_3021);
  endtask

  // General and option inputs reach the option module
  task automatic t_option();
    logic [6:0] p [2] = '{7'h59, 7'h26};
    for (int i = 0; i < 2; i++) begin
      pin_req <= p[i];
      cyc(8);
      chk("options", option_input_o, {p[i][6:3], p[i][0]});
    end
    apb(1'b1, ADDR_IN_MAP, 32'h0654_3921);
    cyc(4);
    chk("gi0 inv", option_input_o[0], 1'b1);
    apb(1'b1, ADDR_IN_MAP, 32'h0654_3021);
    pin_req <= 7'h00;
    cyc(8);
  endtask

  // Brake, routed status functions, software level, output pin map
  task automatic t_outputs();
    brake_release_req_i <= 1'b1;
    cyc(3);
    chk("brake", out_pin_o[0], 1'b1);
    brake_release_req_i <= 1'b0;
    cyc(3);
    chk("brake hold", out_pin_o[0], 1'b0);
    for (int c = 1; c <= 8; c++) begin
      apb(1'b1, ADDR_OUT_FUNC, 32'h0000_0400 | 32'(c << 4));
      st <= 8'h01 << (c - 1);
      cyc(3);
      chk("func", out_pin_o[2:1], {c == 4, 1'b1});
      st <= 8'h00;
      cyc(3);
      chk("func off", out_pin_o[2:1], 2'h0);
    end
    apb(1'b1, ADDR_OUT_FUNC, 32'h0000_0419);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    cyc(2);
    chk("gpo1", out_pin_o[0], 1'b1);
    brake_release_req_i <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    cyc(2);
    chk("gpo1 low", out_pin_o[0], 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    apb(1'b1, ADDR_OUT_PIN, 32'h0000_000B);
    cyc(2);
    chk("pin map", out_pin_o, 3'h4);
    brake_release_req_i <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
  endtask

  // Quadrature steps up and down, then the origin marker
  task automatic t_encoder();
    logic [1:0] g [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    for (int i = 0; i < 4; i++) begin
      step(1'b1);
      chk("quad up", {phase_a_out_o, phase_b_out_o}, g[i]);
    end
    step(1'b0);
    chk("quad down", {phase_a_out_o, phase_b_out_o}, 2'h2);
    enc_origin_i <= 1'b1;
    cyc(2);
    chk("origin", {origin_pulse_out_o, origin_pulse_out_n_o}, 2'h2);
    enc_origin_i <= 1'b0;
    cyc(2);
    chk("origin end", origin_pulse_out_o, 1'b0);
  endtask

  // Each shutoff channel alone cuts current; both light the monitor
  task automatic t_shutoff();
    for (int i = 1; i <= 2; i++) begin
      shut_req <= 2'(i);
      cyc(3);
      chk("cut early", motor_current_off_o, 1'b0);
      cyc(6);
      chk("cut", motor_current_off_o, 1'b1);
      chk("mon one", shutoff_monitor_out_o, 1'b0);
      shut_req <= 2'h3;
      cyc(9);
      chk("run", motor_current_off_o, 1'b0);
    end
    shut_req <= 2'h0;
    cyc(9);
    chk("mon both", shutoff_monitor_out_o, 1'b1);
    apb(1'b0, ADDR_IN_STATE, 32'h0000_0000);
    chk("state", rdata[18:16], 3'h4);
    shut_req <= 2'h3;
    cyc(9);
    chk("mon off", shutoff_monitor_out_o, 1'b0);
    error_detected_i <= 1'b1;
    cyc(2);
    chk("alarm off", alarm_out_o, 1'b0);
    error_detected_i <= 1'b0;
    apb(1'b0, ADDR_IRQ_STAT, 32'h0000_0000);
    chk("events", rdata[3:2], 2'h3);
    chk("alarm on", alarm_out_o, 1'b1);
  endtask

  // Print the counts and the verdict, then stop
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    t_regs();
    t_travel();
    t_option();
    t_outputs();
    t_encoder();
    t_shutoff();
    end_of_test();
  end

  // Cut a hang short; the run needs well under 1000 cycles
  initial begin
    #500us;
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
